/* logic/sfep_core.sv */
// Purpose: erase/program command decode and self-timed sequencing of a serial NOR flash
// Assumes: array macro outside takes erase and byte-write strobes; writes AND into cells
// Notes: link logic runs on sclk; commit happens on synchronised chip select rise
`timescale 1ns/1ps
`include "sfep_regs.svh"
module sfep_core import sfep_pkg::*; #(
	parameter logic [7:0] OP_UNLOCK = `SFEP_OP_UNLOCK_DEF,
	parameter logic [7:0] OP_LARGE = `SFEP_OP_LARGE_DEF,
	parameter logic [7:0] OP_MID = `SFEP_OP_MID_DEF,
	parameter int unsigned SMALL_CYC = `SFEP_CYC(`SFEP_T_SMALL_US),
	parameter int unsigned BLOCK_CYC = `SFEP_CYC(`SFEP_T_BLOCK_US),
	parameter int unsigned ALL_CYC = `SFEP_CYC(`SFEP_T_ALL_US),
	parameter int unsigned PAGE_CYC = `SFEP_CYC(`SFEP_T_PAGE_US)
) (
	input wire logic clk, // core clock
	input wire logic nrst, // sync reset, active low
	input wire logic sclk, // link clock
	input wire logic cs_n, // chip select, active low
	input wire logic [3:0] io_lane, // serial data lanes
	input wire logic four_line_permit_bit, // allows four-line write
	input wire logic protection_scheme_select, // 0 level field, 1 locks
	input wire logic [3:0] protection_level_field, // protected top size
	input wire logic lock_hit, // lock of lock_addr region
	input wire logic lock_any, // some region locked
	output logic operation_busy_flag, // self-timed cycle running
	output logic write_unlock_flag, // write unlocked
	output logic [23:0] lock_addr, // region asked of lock table
	output logic cmd_refused, // command dropped while busy
	output sfep_arr_t arr // array strobes
);
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_CHECK = 5'b00010,
		S_STREAM = 5'b00100,
		S_WAIT = 5'b01000,
		S_DONE = 5'b10000
	} sfep_state_t;

	function automatic logic [23:0] sfep_span(input sfep_wipe_t k);
		unique case (k)
			W_SECT: return `SFEP_SPAN_SECT;
			W_MID: return `SFEP_SPAN_MID;
			W_LARGE: return `SFEP_SPAN_LARGE;
			W_ALL: return `SFEP_SPAN_ALL;
		endcase
	endfunction : sfep_span

	// page writes keep their page base; erases round down to the region start
	function automatic logic [23:0] sfep_base(input logic [23:0] a, input sfep_wipe_t k,
		input logic pg);
		if (pg) begin
			return {a[23:8], 8'h00};
		end
		return a & ~sfep_span(k);
	endfunction : sfep_base

	// level field protects the top 64K << (level-1) bytes; levels 10 to 15 overflow sz and protect nothing
	function automatic logic sfep_level_hit(input logic [23:0] a, input logic [3:0] lv);
		logic [24:0] sz;
		sz = `SFEP_BP_UNIT << (lv - 4'h1);
		if (lv == 4'h0) begin
			return 1'b0;
		end
		if (sz >= `SFEP_ARRAY_TOP) begin
			return 1'b1;
		end
		return {1'b0, a} >= (`SFEP_ARRAY_TOP - sz);
	endfunction : sfep_level_hit

	sfep_frame_t fr;
	sfep_state_t st_q;
	logic cs1_q, cs2_q, cs3_q;
	logic commit;
	logic accept;
	logic go, prog, unlock, aligned;
	sfep_wipe_t kind;
	logic [31:0] cyc;
	sfep_wipe_t kind_q;
	logic prog_q;
	logic [23:0] base_q;
	logic [255:0] mask_q;
	logic [255:0][7:0] page_q;
	logic [7:0] idx_q;
	logic prot;
	logic tmr_load;
	logic [31:0] tmr_cnt;
	logic tmr_done;

	sfep_link u_link (
		.sclk(sclk),
		.cs_n(cs_n),
		.io_lane(io_lane),
		.permit(four_line_permit_bit),
		.frame(fr)
	);

	// one interval counter serves every erase and program cycle
	sfep_timer #(.W(32)) u_timer (
		.clk(clk),
		.nrst(nrst),
		.load(tmr_load),
		.count(tmr_cnt),
		.done(tmr_done)
	);

	// chip select crosses into the core domain; frame is frozen after its rise
	// the link clock is still while chip select is high, so the frame has settled
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cs1_q <= 1'b1;
			cs2_q <= 1'b1;
			cs3_q <= 1'b1;
		end else begin
			cs1_q <= cs_n;
			cs2_q <= cs1_q;
			cs3_q <= cs2_q;
		end
	end

	assign commit = cs2_q && !cs3_q;
	assign aligned = (fr.phase == 3'h0);
	// a cycle starts only from idle, on a whole frame, with the unlock flag set
	assign accept = (st_q == S_IDLE) && commit && go && write_unlock_flag;

	// decode of the frozen frame; erases start a cycle only on exact byte counts, page writes on five or more
	always_comb begin
		go = 1'b0;
		prog = 1'b0;
		kind = W_SECT;
		cyc = 32'(SMALL_CYC);
		unlock = aligned && (fr.opcode == OP_UNLOCK) && (fr.nbytes == `SFEP_NB_OPCODE);
		if (aligned && fr.nbytes == `SFEP_NB_ADDR) begin
			if (fr.opcode == `SFEP_OP_SMALL) begin
				go = 1'b1;
			end else if (fr.opcode == OP_LARGE) begin
				go = 1'b1;
				kind = W_LARGE;
				cyc = 32'(BLOCK_CYC);
			end else if (fr.opcode == OP_MID) begin
				go = 1'b1;
				kind = W_MID;
				cyc = 32'(BLOCK_CYC);
			end
		end
		if (aligned && fr.nbytes == `SFEP_NB_OPCODE &&
			(fr.opcode == `SFEP_OP_ALL_A || fr.opcode == `SFEP_OP_ALL_B)) begin
			go = 1'b1;
			kind = W_ALL;
			cyc = 32'(ALL_CYC);
		end
		// page write needs at least one whole data byte
		if (aligned && fr.nbytes >= `SFEP_NB_DATA_MIN &&
			(fr.opcode == `SFEP_OP_PAGE1 || fr.opcode == `SFEP_OP_PAGE4)) begin
			go = 1'b1;
			prog = 1'b1;
			cyc = 32'(PAGE_CYC);
		end
	end

	// in the level scheme, protection is judged on the last byte of the target region (its 4K sector for page writes)
	always_comb begin
		if (protection_scheme_select) begin
			prot = (kind_q == W_ALL) ? lock_any : lock_hit;
		end else begin
			prot = sfep_level_hit(base_q | sfep_span(kind_q), protection_level_field);
		end
	end

	// sequencer and busy flag
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q <= S_IDLE;
			operation_busy_flag <= 1'b0;
			kind_q <= W_SECT;
			prog_q <= 1'b0;
			base_q <= 24'h000000;
			idx_q <= 8'h00;
			tmr_load <= 1'b0;
			tmr_cnt <= 32'h00000000;
		end else begin
			tmr_load <= 1'b0;
			unique case (st_q)
				S_IDLE: begin
					if (accept) begin
						st_q <= S_CHECK;
						operation_busy_flag <= 1'b1;
						kind_q <= kind;
						prog_q <= prog;
						base_q <= sfep_base(fr.addr, kind, prog);
						tmr_cnt <= cyc;
					end
				end
				S_CHECK: begin
					idx_q <= 8'h00;
					if (prot) begin
						st_q <= S_DONE;
					end else if (prog_q) begin
						st_q <= S_STREAM;
					end else begin
						st_q <= S_WAIT;
						tmr_load <= 1'b1;
					end
				end
				S_STREAM: begin
					idx_q <= idx_q + 8'h01;
					if (idx_q == `SFEP_IDX_LAST) begin
						st_q <= S_WAIT;
						tmr_load <= 1'b1;
					end
				end
				S_WAIT: begin
					if (tmr_done) begin
						st_q <= S_DONE;
					end
				end
				S_DONE: begin
					st_q <= S_IDLE;
					operation_busy_flag <= 1'b0;
				end
			endcase
		end
	end

	// unlock flag: set by the unlock command when idle, cleared at cycle end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			write_unlock_flag <= 1'b0;
		end else if (st_q == S_DONE) begin
			write_unlock_flag <= 1'b0;
		end else if (commit && unlock && !operation_busy_flag) begin
			write_unlock_flag <= 1'b1;
		end
	end

	// busy drops new commands; status pins stay live
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cmd_refused <= 1'b0;
		end else begin
			cmd_refused <= commit && (go || unlock) && operation_busy_flag;
		end
	end

	// page copy taken at commit so a new frame cannot disturb the write
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mask_q <= '0;
		end else if (accept && prog) begin
			mask_q <= fr.mask;
		end
	end

	always_ff @(posedge clk) begin
		if (accept && prog) begin
			page_q <= fr.data;
		end
	end

	// the lock table is asked about the region of the accepted command
	always_ff @(posedge clk) begin
		if (!nrst) begin
			lock_addr <= 24'h000000;
		end else if (accept) begin
			lock_addr <= sfep_base(fr.addr, kind, prog);
		end
	end

	// array strobes; program data only pulls bits from one to zero
	always_ff @(posedge clk) begin
		if (!nrst) begin
			arr <= '0;
		end else begin
			arr.erase <= (st_q == S_CHECK) && !prot && !prog_q;
			arr.wr <= (st_q == S_STREAM) && mask_q[idx_q];
			arr.kind <= kind_q;
			arr.addr <= (st_q == S_STREAM) ? {base_q[23:8], idx_q} : base_q;
			arr.data <= page_q[idx_q];
		end
	end
endmodule : sfep_core

/* logic/sfep_link.sv */
// Purpose: serial front end; shifts opcode, address and page data on the link clock
// Assumes: data sampled on sclk rising; link clock still while chip select is high
// Notes: frame stays frozen while chip select is high and is read by the core then
`timescale 1ns/1ps
`include "sfep_regs.svh"
module sfep_link import sfep_pkg::*; (
	input wire logic sclk, // link clock
	input wire logic cs_n, // chip select, active low
	input wire logic [3:0] io_lane, // serial data lanes
	input wire logic permit, // four-line permit bit, core domain
	output sfep_frame_t frame // captured frame
);
	logic p1_q, p2_q;
	logic [7:0] sh_q, op_q, idx_q;
	logic [23:0] addr_q;
	logic [2:0] cnt_q, ph_q, ph_d;
	logic quad_q;
	logic [255:0] mask_q;
	logic [255:0][7:0] data_q;
	logic [7:0] nb;
	logic byte_done;
	logic live_q, quad_c;
	logic [2:0] ph_c;

	// the first edge of a frame starts from zero; the old frame stays readable until then
	assign quad_c = live_q && quad_q;
	assign ph_c = live_q ? ph_q : 3'h0;
	// upper lanes ignored unless in the four-line phase after the opcode (address and data)
	assign nb = quad_c ? {sh_q[3:0], io_lane} : {sh_q[6:0], io_lane[0]};
	assign ph_d = ph_c + (quad_c ? `SFEP_STEP_4 : `SFEP_STEP_1);
	assign byte_done = (ph_d == 3'h0);

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			p1_q <= 1'b0;
			p2_q <= 1'b0;
		end else begin
			p1_q <= permit;
			p2_q <= p1_q;
		end
	end

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			live_q <= 1'b0;
		end else begin
			live_q <= 1'b1;
		end
	end

	always_ff @(posedge sclk) begin
		if (!cs_n) begin
			sh_q <= nb;
			ph_q <= ph_d;
			if (!live_q) begin
				cnt_q <= 3'h0;
				quad_q <= 1'b0;
				mask_q <= '0;
			end else if (byte_done) begin
				if (cnt_q != `SFEP_NB_SAT) begin
					cnt_q <= cnt_q + 3'h1;
				end
				unique case (cnt_q)
					3'h0: begin
						op_q <= nb;
						quad_q <= (nb == `SFEP_OP_PAGE4) && p2_q;
					end
					3'h1: addr_q[23:16] <= nb;
					3'h2: addr_q[15:8] <= nb;
					3'h3: begin
						addr_q[7:0] <= nb;
						idx_q <= nb;
					end
					default: begin
						mask_q[idx_q] <= 1'b1;
						idx_q <= idx_q + 8'h01; // wraps in the page
					end
				endcase
			end
		end
	end

	always_ff @(posedge sclk) begin
		if (!cs_n && byte_done && cnt_q >= `SFEP_NB_ADDR) begin
			data_q[idx_q] <= nb; // later bytes overwrite earlier ones
		end
	end

	assign frame = '{opcode: op_q, addr: addr_q, nbytes: cnt_q, phase: ph_q,
		quad: quad_q, mask: mask_q, data: data_q};
endmodule : sfep_link

/* logic/sfep_timer.sv */
// Purpose: self-timed interval counter for erase and program cycles
// Assumes: load is a one-cycle pulse
// Notes: done pulses one cycle when the loaded count has run out
`timescale 1ns/1ps
module sfep_timer #(
	parameter int W = 32
) (
	input wire logic clk, // core clock
	input wire logic nrst, // sync reset, active low
	input wire logic load, // start interval
	input wire logic [W-1:0] count, // interval in cycles
	output logic done // end of interval
);
	logic [W-1:0] cnt_q;
	logic run_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				cnt_q <= count;
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q <= W'(1)) begin
					run_q <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_q <= cnt_q - W'(1);
				end
			end
		end
	end
endmodule : sfep_timer

/* shared/sfep_pkg.sv */
// Purpose: shared types of the erase/program sequencer
// Assumes: 24-bit byte address, 256-byte page
// Notes: frame is filled on the serial clock, read on the core clock
package sfep_pkg;

	typedef enum logic [1:0] {
		W_SECT = 2'h0,
		W_MID = 2'h1,
		W_LARGE = 2'h2,
		W_ALL = 2'h3
	} sfep_wipe_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [2:0] nbytes;
		logic [2:0] phase;
		logic quad;
		logic [255:0] mask;
		logic [255:0][7:0] data;
	} sfep_frame_t;

	typedef struct packed {
		logic erase;
		logic wr;
		sfep_wipe_t kind;
		logic [23:0] addr;
		logic [7:0] data;
	} sfep_arr_t;

endpackage : sfep_pkg

/* shared/sfep_regs.svh */
// Purpose: opcode, geometry and timing constants of the erase/program sequencer
// Assumes: core clock in MHz given below; times in microseconds
// Notes: definitions only
`ifndef SFEP_REGS_SVH
`define SFEP_REGS_SVH

`define SFEP_OP_SMALL 8'h20
`define SFEP_OP_ALL_A 8'h60
`define SFEP_OP_ALL_B 8'hC7
`define SFEP_OP_PAGE1 8'h02
`define SFEP_OP_PAGE4 8'h38
`define SFEP_OP_UNLOCK_DEF 8'h06
`define SFEP_OP_LARGE_DEF 8'hD8
`define SFEP_OP_MID_DEF 8'h52

`define SFEP_NB_OPCODE 3'h1
`define SFEP_NB_ADDR 3'h4
`define SFEP_NB_DATA_MIN 3'h5
`define SFEP_NB_SAT 3'h7
`define SFEP_STEP_1 3'h1
`define SFEP_STEP_4 3'h4
`define SFEP_IDX_LAST 8'hFF

`define SFEP_SPAN_SECT 24'h000FFF
`define SFEP_SPAN_MID 24'h007FFF
`define SFEP_SPAN_LARGE 24'h00FFFF
`define SFEP_SPAN_ALL 24'hFFFFFF
`define SFEP_BP_UNIT 25'h0010000
`define SFEP_ARRAY_TOP 25'h1000000

`define SFEP_CLK_MHZ 50
`define SFEP_T_SMALL_US 40
`define SFEP_T_BLOCK_US 400
`define SFEP_T_ALL_US 20000
`define SFEP_T_PAGE_US 60
`define SFEP_CYC(us) ((us) * `SFEP_CLK_MHZ)

`endif

/* testbench/sfep_checker.sv */
// Purpose: port assertions for the erase/program sequencer
// Assumes: core clock domain only
// Notes: bound into sfep_core
`timescale 1ns/1ps
module sfep_checker import sfep_pkg::*; (
	input wire logic clk, // core clock
	input wire logic nrst, // sync reset, active low
	input wire logic protection_scheme_select, // scheme
	input wire logic [3:0] protection_level_field, // level
	input wire logic lock_any, // any lock
	input wire logic operation_busy_flag, // busy
	input wire logic write_unlock_flag, // unlocked
	input wire logic cmd_refused, // refused pulse
	input sfep_arr_t arr // array strobes
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_start; $rose(operation_busy_flag); endsequence
	sequence s_done; $fell(operation_busy_flag); endsequence
	property p_gate; s_start |-> write_unlock_flag; endproperty
	a_gate: assert property (p_gate) else $error("cycle began locked");
	property p_end; s_done |-> !write_unlock_flag; endproperty
	a_end: assert property (p_end) else $error("unlock kept at end");
	property p_ers; arr.erase |-> operation_busy_flag ##1 !arr.erase; endproperty
	a_ers: assert property (p_ers) else $error("bad erase strobe");
	property p_wr; arr.wr |-> operation_busy_flag && !arr.erase; endproperty
	a_wr: assert property (p_wr) else $error("write outside cycle");
	property p_sect; arr.erase && arr.kind == W_SECT |-> arr.addr[11:0] == 12'h000; endproperty
	a_sect: assert property (p_sect) else $error("sector not aligned");
	property p_blk;
		arr.erase && arr.kind inside {W_MID, W_LARGE} |->
			arr.addr[14:0] == 15'h0000 && (arr.kind == W_MID || !arr.addr[15]);
	endproperty
	a_blk: assert property (p_blk) else $error("block not aligned");
	property p_all;
		arr.erase && arr.kind == W_ALL |-> arr.addr == 24'h000000 &&
			(protection_scheme_select ? !lock_any : protection_level_field == 4'h0);
	endproperty
	a_all: assert property (p_all) else $error("bad array wipe");
	property p_prot; arr.erase || arr.wr |-> protection_scheme_select || protection_level_field < 4'h9; endproperty
	a_prot: assert property (p_prot) else $error("protected array changed");
	property p_ref; cmd_refused |-> $past(operation_busy_flag) ##1 !cmd_refused; endproperty
	a_ref: assert property (p_ref) else $error("refusal while idle");
endmodule : sfep_checker

bind sfep_core sfep_checker chk (.clk(clk), .nrst(nrst),
	.protection_scheme_select(protection_scheme_select),
	.protection_level_field(protection_level_field), .lock_any(lock_any),
	.operation_busy_flag(operation_busy_flag), .write_unlock_flag(write_unlock_flag),
	.cmd_refused(cmd_refused), .arr(arr));

/* testbench/sfep_core_test.sv */
// Purpose: self-checking bench for the erase/program sequencer
// Assumes: cycle counts shortened to 20
// Notes: array strobes are queued and compared per test
`timescale 1ns/1ps
module sfep_core_test import sfep_pkg::*; ;
	localparam logic [35:0] ME = 36'hFFFFFFF00;
	localparam logic [35:0] MW = 36'hCFFFFFFFF;
	logic clk = 1'b0, nrst = 1'b0, permit = 1'b0, sel = 1'b0, hit = 1'b0, any_lk = 1'b0;
	logic [3:0] lvl = 4'h0;
	logic sclk, cs_n, busy, unl, refd;
	logic [3:0] io;
	logic [23:0] la;
	logic [6:0] pc[4] = '{7'h24, 7'h43, 7'h41, 7'h04};
	sfep_arr_t arr;
	sfep_arr_t ev[$];
	int bad_count = 0, n_tests = 0, nref = 0;
	always #10 clk = ~clk;
	sfep_host host (.sclk(sclk), .cs_n(cs_n), .io_lane(io));
	sfep_core #(.SMALL_CYC(20), .BLOCK_CYC(20), .ALL_CYC(20), .PAGE_CYC(20)) dut (
		.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .io_lane(io),
		.four_line_permit_bit(permit), .protection_scheme_select(sel),
		.protection_level_field(lvl), .lock_hit(hit), .lock_any(any_lk),
		.operation_busy_flag(busy), .write_unlock_flag(unl), .lock_addr(la),
		.cmd_refused(refd), .arr(arr));
	always @(negedge clk) begin
		if (arr.erase === 1'b1 || arr.wr === 1'b1) ev.push_back(arr);
		if (refd === 1'b1) nref++;
	end
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic ev_is(input int i, input logic [35:0] m, input logic [35:0] x);
		sfep_arr_t e;
		e = 'x;
		if (i < ev.size()) e = ev[i];
		chk(e & m, x);
	endtask : ev_is
	task automatic fin;
		int i;
		repeat (6) @(negedge clk);
		for (i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk);
		repeat (2) @(negedge clk);
	endtask : fin
	task automatic op(input logic [7:0] b[$], input int nb, input bit quad);
		host.xfer(b, nb, quad);
		fin;
	endtask : op
	task automatic unlock;
		op({8'h06}, 8, 0);
		chk(unl, 1'b1);
		ev = {};
	endtask : unlock
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		end_of_test;
	end
	initial begin
		int i;
		logic [7:0] f[$];
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		op({8'h20, 8'h12, 8'h34, 8'h56}, 32, 0);
		chk(ev.size(), 0);
		unlock;
		op({8'h20, 8'h12, 8'h34, 8'h56}, 32, 0);
		ev_is(0, ME, {2'b10, W_SECT, 24'h123000, 8'h00});
		chk(unl, 1'b0);
		unlock;
		op({8'h52, 8'h00, 8'hAB, 8'hCD}, 32, 0);
		ev_is(0, ME, {2'b10, W_MID, 24'h008000, 8'h00});
		unlock;
		op({8'hD8, 8'h12, 8'hAB, 8'hCD}, 32, 0);
		ev_is(0, ME, {2'b10, W_LARGE, 24'h120000, 8'h00});
		unlock;
		op({8'h60}, 8, 0);
		ev_is(0, ME, {2'b10, W_ALL, 24'h000000, 8'h00});
		unlock;
		op({8'hC7}, 8, 0);
		ev_is(0, ME, {2'b10, W_ALL, 24'h000000, 8'h00});
		$display("erase test done");
		unlock;
		op({8'h20, 8'h12, 8'h34, 8'h56}, 31, 0);
		op({8'h20, 8'h12, 8'h34, 8'h56, 8'h00}, 33, 0);
		op({8'hC7, 8'h00}, 16, 0);
		op({8'h02, 8'h00, 8'h00, 8'h00, 8'h11, 8'h22}, 44, 0);
		chk(ev.size(), 0);
		$display("boundary test done");
		for (i = 0; i < 4; i++) begin
			{sel, lvl, hit, any_lk} = pc[i];
			unlock;
			if (i < 2) op({8'h20, 8'hFF, 8'hF0, 8'h00}, 32, 0);
			else op({8'h60}, 8, 0);
			chk(ev.size(), 0);
			chk(unl, 1'b0);
		end
		{sel, lvl, hit, any_lk} = 7'h00;
		$display("protection test done");
		unlock;
		host.xfer({8'h02, 8'h45, 8'h67, 8'hFE, 8'hAA, 8'h55, 8'h0F}, 56, 0);
		repeat (8) @(negedge clk);
		chk(busy, 1'b1);
		host.xfer({8'h06}, 8, 0);
		fin;
		chk(nref, 1);
		chk(unl, 1'b0);
		ev_is(0, MW, {4'h4, 24'h456700, 8'h0F});
		ev_is(1, MW, {4'h4, 24'h4567FE, 8'hAA});
		ev_is(2, MW, {4'h4, 24'h4567FF, 8'h55});
		unlock;
		f = {8'h02, 8'h00, 8'h01, 8'h00};
		for (i = 0; i < 258; i++) f.push_back(i[7:0] ^ {i[8], 7'h5A});
		op(f, 8 * 262, 0);
		chk(ev.size(), 256);
		ev_is(0, MW, {4'h4, 24'h000100, 8'hDA});
		ev_is(1, MW, {4'h4, 24'h000101, 8'hDB});
		ev_is(2, MW, {4'h4, 24'h000102, 8'h58});
		$display("page test done");
		for (i = 0; i < 2; i++) begin
			permit = !i[0];
			unlock;
			op({8'h38, 8'h00, 8'h02, 8'h10, 8'h3C, 8'hC3}, 48, !i[0]);
			ev_is(0, MW, {4'h4, 24'h000210, 8'h3C});
			ev_is(1, MW, {4'h4, 24'h000211, 8'hC3});
		end
		$display("four-line test done");
		end_of_test;
	end
endmodule : sfep_core_test

/* testbench/sfep_host.sv */
// Purpose: host that shifts command frames into the flash
// Assumes: 64 ns link clock, still between frames
// Notes: lanes toggle while deselected so stale data is never seen
`timescale 1ns/1ps
module sfep_host (
	output logic sclk, // link clock
	output logic cs_n, // chip select, active low
	output logic [3:0] io_lane // data lanes
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_lane = 4'h0;
	end
	// msb first; after the opcode a quad frame moves a nibble per clock
	task automatic xfer(input logic [7:0] b[$], input int nb, input bit quad);
		int p;
		p = 0;
		cs_n = 1'b0;
		while (p < nb) begin
			if (quad && p >= 8) begin
				io_lane = p[2] ? b[p / 8][3:0] : b[p / 8][7:4];
				p += 4;
			end else begin
				io_lane = {~io_lane[3:1], b[p / 8][7 - p % 8]}; // junk on upper lanes
				p += 1;
			end
			#32 sclk = 1'b1; // slow clock kept for four-line data
			#32 sclk = 1'b0;
		end
		#16 cs_n = 1'b1; // chosen bit count ends the frame
		io_lane = ~io_lane;
	endtask : xfer
endmodule : sfep_host
